// file: hw/sarcv_dev.sv
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Host holds start high at least 500 ns.
// - Start rise resets sequencer, result, done high.
// - Approximation begins only on start fall.
// - Done goes low when result valid.
// - Host keeps enables high while converting; sarcv_host pulls one low on a read of its own location, even mid-conversion.
// - Early enable shows partial approximation value.
// - Drive data only while its enable low.
// - Left justified: eight upper, two lower bits.
// - Host masks low byte with top two bits.
// - Conversion finishes within 30 microseconds.
// - Blind host waits 30 microseconds before reading.
// - Host decodes two consecutive byte locations.
// - Base write makes start, data ignored.
// - Base read enables upper byte.
// - Next location: write nothing, read lower bits.
// - Strobes gated with decoded address.
// - Host may poll done instead of waiting.
module sarcv_dev
   import sarcv_pkg::*;
#(
   parameter int BIT_CYC = BIT_CYC_DEF
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   sarcv_if.dev bus,
   input wire logic [RES_W-1:0] i_sample,
   output logic o_busy
);
   // ****************************************************************
   // Sequencer
   // ****************************************************************
   typedef enum logic [1:0] {IDLE, ARMED, CONV} sarcv_state_t;
   sarcv_state_t state_ff;
   logic start_d_ff;
   logic [RES_W-1:0] sar_ff;
   logic [3:0] bit_ff;
   logic done_n_ff;
   logic tick;
   logic rise;
   logic fall;
   // The comparator is modelled by a plain compare of the trial code with a sampled input.
   logic [RES_W-1:0] trial;

   assign rise = bus.start && !start_d_ff;
   assign fall = !bus.start && start_d_ff;
   assign trial = sar_ff | (RES_W'(1) << bit_ff);

   sarcv_tick #(
      .DIV(BIT_CYC)
   ) u_tick (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_run(state_ff == CONV),
      .o_tick(tick)
   );

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         start_d_ff <= 1'b0;
      end else begin
         start_d_ff <= bus.start;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         state_ff <= IDLE;
      end else begin
         case (state_ff)
            IDLE: begin
               if (rise) begin
                  state_ff <= ARMED;
               end
            end
            ARMED: begin
               if (fall) begin
                  state_ff <= CONV;
               end
            end
            CONV: begin
               if (rise) begin
                  state_ff <= ARMED;
               end else if (tick && bit_ff == 4'h0) begin
                  state_ff <= IDLE;
               end
            end
            default: begin
               state_ff <= IDLE;
            end
         endcase
      end
   end

   // Ten bit decisions at BIT_CYC each keep the cycle near 20 us, inside the 30 us limit.
   always_ff @(posedge i_mclk) begin
      if (i_rst || rise) begin
         sar_ff <= RES_RST;
         bit_ff <= 4'(RES_W - 1);
      end else if (state_ff == CONV && tick) begin
         if (trial <= i_sample) begin
            sar_ff <= trial;
         end
         if (bit_ff != 4'h0) begin
            bit_ff <= bit_ff - 4'h1;
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         done_n_ff <= 1'b0;
      end else if (rise) begin
         done_n_ff <= 1'b1;
      end else if (state_ff == CONV && tick && bit_ff == 4'h0) begin
         done_n_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // Output buffers
   // ****************************************************************
   // Data is the live register, so an early read sees the partial value.
   assign bus.upper_result_bits = sar_ff[RES_W-1:UPPER_LSB];
   assign bus.lower_result_bits = sar_ff[LOWER_W-1:0];
   assign bus.upper_oe = !bus.hi_byte_en_n;
   assign bus.lower_oe = !bus.lo_byte_en_n;
   assign bus.done_n = done_n_ff;
   assign o_busy = (state_ff != IDLE);
endmodule
`default_nettype wire

// file: hw/sarcv_pkg.sv
package sarcv_pkg;
   // ****************************************************************
   // Widths and data layout
   // ****************************************************************
   localparam int RES_W = 10;
   localparam int BUS_W = 8;
   localparam int UPPER_W = 8;
   localparam int LOWER_W = 2;
   localparam int UPPER_LSB = 2;
   localparam int LOWER_POS = 6;
   localparam logic [7:0] LOW_MASK = 8'hC0;
   localparam logic [RES_W-1:0] RES_RST = 10'h000;
   // ****************************************************************
   // Host locations
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] BASE_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] LOW_OFS = 8'h01;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int START_MIN_NS = 500;
   localparam int START_CYC = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_US = 30;
   localparam int CONV_MAX_CYC = (CONV_MAX_US * 1000) / CLK_PERIOD_NS;
   localparam int CONV_TYP_US = 20;
   localparam int CONV_TYP_CYC = (CONV_TYP_US * 1000) / CLK_PERIOD_NS;
   localparam int BIT_CYC_DEF = CONV_TYP_CYC / RES_W;
   localparam int CNT_W = 16;
endpackage

// file: hw/sarcv_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sarcv_if;
   import sarcv_pkg::*;
   logic start;
   logic done_n;
   logic hi_byte_en_n;
   logic lo_byte_en_n;
   logic [UPPER_W-1:0] upper_result_bits;
   logic [LOWER_W-1:0] lower_result_bits;
   logic upper_oe;
   logic lower_oe;
   modport dev (
      input start,
      input hi_byte_en_n,
      input lo_byte_en_n,
      output done_n,
      output upper_result_bits,
      output lower_result_bits,
      output upper_oe,
      output lower_oe
   );
   modport host (
      output start,
      output hi_byte_en_n,
      output lo_byte_en_n,
      input done_n,
      input upper_result_bits,
      input lower_result_bits,
      input upper_oe,
      input lower_oe
   );
endinterface
`default_nettype wire

// file: hw/sarcv_tick.sv
`timescale 1ns/100ps
`default_nettype none
module sarcv_tick
   import sarcv_pkg::*;
#(
   parameter int DIV = BIT_CYC_DEF
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_run,
   output logic o_tick
);
   logic [CNT_W-1:0] cnt_ff;
   always_ff @(posedge i_mclk) begin
      if (i_rst || !i_run) begin
         cnt_ff <= '0;
      end else if (cnt_ff == CNT_W'(DIV - 1)) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
   assign o_tick = i_run && (cnt_ff == CNT_W'(DIV - 1));
endmodule
`default_nettype wire

// file: hw/sarcv_host.sv
`timescale 1ns/100ps
`default_nettype none
module sarcv_host
   import sarcv_pkg::*;
#(
   parameter logic [ADDR_W-1:0] BASE = BASE_OFS
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   sarcv_if.host bus,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [BUS_W-1:0] i_wdata,
   output logic [BUS_W-1:0] o_rdata,
   output logic o_done,
   output logic o_eoc
);
   logic sel_base;
   logic sel_low;
   logic [5:0] hold_ff;
   logic done_d_ff;
   logic [BUS_W-1:0] rdata_ff;

   assign sel_base = (i_addr == BASE);
   assign sel_low = (i_addr == ADDR_W'(BASE + LOW_OFS));

   // A one-cycle write strobe is stretched so the start pulse meets its minimum width.
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         hold_ff <= 6'h00;
      end else if (i_wr && sel_base) begin
         hold_ff <= 6'(START_CYC);
      end else if (hold_ff != 6'h00) begin
         hold_ff <= hold_ff - 6'h01;
      end
   end
   assign bus.start = (hold_ff != 6'h00);

   assign bus.hi_byte_en_n = !(i_rd && sel_base);
   assign bus.lo_byte_en_n = !(i_rd && sel_low);

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rdata_ff <= 8'h00;
      end else if (i_rd && sel_base && bus.upper_oe) begin
         rdata_ff <= bus.upper_result_bits;
      end else if (i_rd && sel_low && bus.lower_oe) begin
         rdata_ff <= {bus.lower_result_bits, 6'h00} & LOW_MASK;
      end
   end
   assign o_rdata = rdata_ff;

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         done_d_ff <= 1'b0;
      end else begin
         done_d_ff <= bus.done_n;
      end
   end
   assign o_done = !bus.done_n;
   assign o_eoc = done_d_ff && !bus.done_n;
endmodule
`default_nettype wire

// file: testbench/sarcv_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Interface checks.
// ****
module sarcv_sva
   import sarcv_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic start,
   input wire logic done_n,
   input wire logic hi_byte_en_n,
   input wire logic lo_byte_en_n,
   input wire logic [UPPER_W-1:0] upper_result_bits,
   input wire logic [LOWER_W-1:0] lower_result_bits,
   input wire logic upper_oe,
   input wire logic lower_oe
);
   // A restart cuts a conversion short, so it also ends the wait.
   localparam int LIM = 400;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   int st_cnt_ff;
   int cv_cnt_ff;
   // Counters stand in for long repetitions, which would be slow to unroll.
   always_ff @(posedge i_mclk) begin
      if (i_rst || !start) begin
         st_cnt_ff <= 0;
      end else begin
         st_cnt_ff <= st_cnt_ff + 1;
      end
   end
   always_ff @(posedge i_mclk) begin
      if (i_rst || start || !done_n) begin
         cv_cnt_ff <= 0;
      end else if (cv_cnt_ff <= CONV_MAX_CYC) begin
         cv_cnt_ff <= cv_cnt_ff + 1;
      end
   end
   sequence sar_zero;
      upper_result_bits == 8'h00 && lower_result_bits == 2'h0;
   endsequence
   sequence conv_end;
      ##[1:LIM] (!done_n || start);
   endsequence
   sequence held_idle;
      !done_n && !start;
   endsequence
   done_clear_a: assert property ($rose(start) |=> done_n)
      else $error("done not raised by start");
   sar_clear_a: assert property ($rose(start) |=> sar_zero)
      else $error("result not cleared by start");
   start_hold_a: assert property (start |=> done_n)
      else $error("done low while start high");
   conv_bound_a: assert property ($fell(start) |-> conv_end)
      else $error("conversion did not finish in time");
   result_hold_a: assert property (held_idle |=> !done_n && $stable(upper_result_bits))
      else $error("result not held after done");
   hi_drive_a: assert property (upper_oe == !hi_byte_en_n)
      else $error("upper drive does not follow enable");
   lo_drive_a: assert property (lower_oe == !lo_byte_en_n)
      else $error("lower drive does not follow enable");
   one_byte_a: assert property (hi_byte_en_n || lo_byte_en_n)
      else $error("both byte enables low");
   start_width_a: assert property ($fell(start) |-> st_cnt_ff >= START_CYC)
      else $error("start pulse too short");
   conv_time_a: assert property (cv_cnt_ff <= CONV_MAX_CYC)
      else $error("conversion longer than limit");
endmodule
`default_nettype wire

// file: testbench/sar_adc_convert_and_read_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench.
// ****
module sar_adc_convert_and_read_port_tb_top;
   import sarcv_pkg::*;
   // A short bit time keeps each conversion near thirty cycles.
   localparam int BC = 3;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [ADDR_W-1:0] addr = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [BUS_W-1:0] wdata = 8'h00;
   logic [RES_W-1:0] smp = 10'h000;
   logic [BUS_W-1:0] rdata;
   logic busy;
   logic done;
   logic eoc;
   int num_errors = 0;
   int tests_run = 0;
   int seed = 32'h4F64;
   int k;
   sarcv_if u_sarcv_if ();
   sarcv_dev #(.BIT_CYC(BC)) u_sarcv_dev (.i_mclk(i_mclk), .i_rst(i_rst),
      .bus(u_sarcv_if.dev), .i_sample(smp), .o_busy(busy));
   sarcv_host u_sarcv_host (.i_mclk(i_mclk), .i_rst(i_rst), .bus(u_sarcv_if.host),
      .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
      .o_done(done), .o_eoc(eoc));
   sarcv_sva u_sarcv_sva (.i_mclk(i_mclk), .i_rst(i_rst), .start(u_sarcv_if.start),
      .done_n(u_sarcv_if.done_n), .hi_byte_en_n(u_sarcv_if.hi_byte_en_n),
      .lo_byte_en_n(u_sarcv_if.lo_byte_en_n), .upper_oe(u_sarcv_if.upper_oe),
      .upper_result_bits(u_sarcv_if.upper_result_bits), .lower_oe(u_sarcv_if.lower_oe),
      .lower_result_bits(u_sarcv_if.lower_result_bits));
   initial begin
      forever #5 i_mclk = ~i_mclk;
   end
   function automatic logic [1:0] exp_oe(input logic [7:0] a, input logic w);
      exp_oe = w ? 2'b00 : {a == BASE_OFS, a == LOW_OFS};
   endfunction
   function automatic logic [7:0] exp_rd(input logic [9:0] s, input logic lo);
      exp_rd = lo ? {s[1:0], 6'h00} : s[9:2];
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic acc(input logic [7:0] a, input logic w);
      @(posedge i_mclk);
      addr <= a;
      wr <= w;
      rd <= !w;
      #1;
      check(16'({u_sarcv_if.upper_oe, u_sarcv_if.lower_oe}), 16'(exp_oe(a, w)));
      @(posedge i_mclk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
   endtask
   task automatic conv(input logic [RES_W-1:0] s, input logic early);
      int n;
      int w;
      logic [BUS_W-1:0] p;
      p = 8'h00;
      @(posedge i_mclk);
      smp <= s;
      wdata <= 8'($random(seed));
      acc(BASE_OFS, 1'b1);
      w = 0;
      for (n = 0; n < 300 && (w == 0 || u_sarcv_if.start === 1'b1); n++) begin
         w += int'(u_sarcv_if.start === 1'b1);
         @(posedge i_mclk);
         #1;
      end
      check(16'(w), 16'(START_CYC));
      check(16'(done), 16'h0000);
      check(16'(busy), 16'h0001);
      // The early read lands a few decisions into the conversion, so for a sample of 10'h3FF the partial value is not empty.
      if (early) begin
         repeat (12) @(posedge i_mclk);
         acc(BASE_OFS, 1'b0);
         p = rdata;
         check(16'(done), 16'h0000);
      end
      for (n = 0; n < CONV_MAX_CYC && done !== 1'b1; n++) begin
         @(posedge i_mclk);
         #1;
      end
      if (n == CONV_MAX_CYC) begin
         num_errors++;
         return;
      end
      check(16'(eoc), 16'h0001);
      acc(BASE_OFS, 1'b0);
      check(16'(rdata), 16'(exp_rd(s, 1'b0)));
      check(16'(p & ~exp_rd(s, 1'b0)), 16'h0000);
      acc(LOW_OFS, 1'b0);
      check(16'(rdata & LOW_MASK), 16'(exp_rd(s, 1'b1)));
   endtask
   initial begin
      repeat (20) @(posedge i_mclk);
      i_rst <= 1'b0;
      conv(10'h000, 1'b0);
      conv(10'h3FF, 1'b1);
      acc(LOW_OFS, 1'b1);
      repeat (3) @(posedge i_mclk);
      check(16'(busy), 16'h0000);
      check(16'(done), 16'h0001);
      acc(BASE_OFS, 1'b0);
      check(16'(rdata), 16'h00FF);
      acc(8'h02, 1'b0);
      acc(BASE_OFS, 1'b1);
      repeat (60) @(posedge i_mclk);
      conv(10'h2AA, 1'b0);
      for (k = 0; k < 12; k++) begin
         conv(10'($random(seed)), k[0]);
      end
      final_report();
   end
endmodule
`default_nettype wire
